// ===== verilog/cpc_defines.vh
`ifndef CPC_DEFINES_VH
`define CPC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CPC_OFF_CTRL 5'h00
`define CPC_OFF_CH3_LO 5'h04
`define CPC_OFF_CH3_HI 5'h08
`define CPC_OFF_CH4_LO 5'h0c
`define CPC_OFF_CH4_HI 5'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CPC_BIT_PULSE3_EN 0
`define CPC_BIT_CH3_SEL_LO 1
`define CPC_BIT_CH3_SEL_HI 2
`define CPC_BIT_CH4_SEL_LO 3
`define CPC_BIT_CH4_SEL_HI 4
`define CPC_BIT_CH3_OVF 5
`define CPC_BIT_CH4_OVF 6
`define CPC_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Capture modes and prescale counts
// ----------------------------------------------------------------
`define CPC_MODE_FALL 2'h0
`define CPC_MODE_RISE 2'h1
`define CPC_MODE_RISE4 2'h2
`define CPC_MODE_RISE16 2'h3
`define CPC_DIV4_LAST 4'h3
`define CPC_DIV16_LAST 4'hf

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2

`endif

// ===== verilog/cpc_capture_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.vh"

module cpc_capture_chan #(
  parameter TB_WIDTH = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Configuration and pin
  input wire [1:0] mode,
  input wire cap_pin,
  input wire [TB_WIDTH-1:0] capture_timebase,
  // Software read strobes for the two bytes
  input wire rd_lo,
  input wire rd_hi,
  // State seen by software
  output reg [TB_WIDTH-1:0] value_reg,
  output reg overflow_reg
);

  reg pin_prev_reg;
  reg [1:0] mode_prev_reg;
  reg [3:0] div_reg;
  reg [3:0] div_next;
  reg unread_reg;
  reg lo_seen_reg;
  reg hi_seen_reg;
  reg rise;
  reg fall;
  reg event_hit;
  wire both_read;

  // Edge detection and trigger selection
  // trigger mode select
  always @* begin
    rise = cap_pin & ~pin_prev_reg;
    fall = ~cap_pin & pin_prev_reg;
    div_next = div_reg;
    event_hit = 1'b0;
    case (mode)
      `CPC_MODE_FALL: event_hit = fall;
      `CPC_MODE_RISE: event_hit = rise;
      `CPC_MODE_RISE4: begin
        if (rise) begin
          event_hit = (div_reg == `CPC_DIV4_LAST);
          div_next = event_hit ? 4'h0 : div_reg + 4'h1;
        end
      end
      default: begin
        if (rise) begin
          event_hit = (div_reg == `CPC_DIV16_LAST);
          div_next = div_reg + 4'h1;
        end
      end
    endcase
    // A mode change restarts the prescaler; a rise in the change cycle is still tested against the old count
    if (mode != mode_prev_reg) begin
      div_next = 4'h0;
    end
  end

  // Pair counts as read once both bytes have been read since the load
  assign both_read = (lo_seen_reg | rd_lo) & (hi_seen_reg | rd_hi);

  // Capture, hold and overflow
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_reg <= 1'b0;
      mode_prev_reg <= 2'h0;
      div_reg <= 4'h0;
      unread_reg <= 1'b0;
      lo_seen_reg <= 1'b0;
      hi_seen_reg <= 1'b0;
      value_reg <= {TB_WIDTH{1'b0}};
      overflow_reg <= 1'b0;
    end else begin
      pin_prev_reg <= cap_pin;
      mode_prev_reg <= mode;
      div_reg <= div_next;
      if (rd_lo) begin
        lo_seen_reg <= 1'b1;
      end
      if (rd_hi) begin
        hi_seen_reg <= 1'b1;
      end
      if (unread_reg && both_read) begin
        unread_reg <= 1'b0;
        overflow_reg <= 1'b0;
      end
      if (event_hit) begin
        if (unread_reg && !both_read) begin
          overflow_reg <= 1'b1;
        end else begin
          // Read completing this cycle releases the pair for the new value
          value_reg <= capture_timebase;
          unread_reg <= 1'b1;
          lo_seen_reg <= 1'b0;
          hi_seen_reg <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verilog/cpc_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.vh"

module cpc_axil_slave #(
  parameter ADDR_WIDTH = 5
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Register file side
  output wire wr_en,
  output reg [ADDR_WIDTH-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire rd_en,
  output wire [ADDR_WIDTH-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);

  reg aw_held_reg;
  reg w_held_reg;

  // Address and data may arrive in either order; each is held until both
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_en = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_en = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_addr <= {ADDR_WIDTH{1'b0}};
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `CPC_RESP_SLVERR : `CPC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path, one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CPC_RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `CPC_RESP_SLVERR : `CPC_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/cpc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.vh"

module cpc_top #(
  parameter ADDR_WIDTH = 5,
  parameter TB_WIDTH = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Shared capture timebase
  input wire [TB_WIDTH-1:0] capture_timebase,
  // Capture input pins
  input wire cap_ch3_pin,
  input wire cap_ch4_pin,
  // Pulse output 3 shared pin
  input wire pulse_out3_wave,
  input wire port_dir_input,
  input wire port_data_out,
  output reg pulse_out3_pin_out,
  output reg pulse_out3_pin_oe
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  wire wr_en;
  wire [ADDR_WIDTH-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  wire [ADDR_WIDTH-1:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;

  cpc_axil_slave #(
    .ADDR_WIDTH(ADDR_WIDTH)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ----------------------------------------------------------------
  // Control register: enable and the two mode fields
  // ----------------------------------------------------------------
  reg pulse_out3_enable_reg;
  reg [1:0] cap_ch3_mode_reg;
  reg [1:0] cap_ch4_mode_reg;
  wire ctrl_wr;
  // Reset image of the control byte, sliced per field so widths match
  localparam [7:0] CTRL_RST = `CPC_CTRL_RESET;

  // Only byte lane 0 carries the control bits; flags are read only
  assign ctrl_wr = wr_en & (wr_addr == `CPC_OFF_CTRL) & wr_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out3_enable_reg <= CTRL_RST[`CPC_BIT_PULSE3_EN];
      cap_ch3_mode_reg <= CTRL_RST[`CPC_BIT_CH3_SEL_HI:`CPC_BIT_CH3_SEL_LO];
      cap_ch4_mode_reg <= CTRL_RST[`CPC_BIT_CH4_SEL_HI:`CPC_BIT_CH4_SEL_LO];
    end else if (ctrl_wr) begin
      pulse_out3_enable_reg <= wr_data[`CPC_BIT_PULSE3_EN];
      cap_ch3_mode_reg <=
        wr_data[`CPC_BIT_CH3_SEL_HI:`CPC_BIT_CH3_SEL_LO];
      cap_ch4_mode_reg <=
        wr_data[`CPC_BIT_CH4_SEL_HI:`CPC_BIT_CH4_SEL_LO];
    end
  end

  // ----------------------------------------------------------------
  // Read strobes that release a captured pair
  // ----------------------------------------------------------------
  wire ch3_rd_lo;
  wire ch3_rd_hi;
  wire ch4_rd_lo;
  wire ch4_rd_hi;

  assign ch3_rd_lo = rd_en & (rd_addr == `CPC_OFF_CH3_LO);
  assign ch3_rd_hi = rd_en & (rd_addr == `CPC_OFF_CH3_HI);
  assign ch4_rd_lo = rd_en & (rd_addr == `CPC_OFF_CH4_LO);
  assign ch4_rd_hi = rd_en & (rd_addr == `CPC_OFF_CH4_HI);

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  wire [TB_WIDTH-1:0] ch3_value;
  wire [TB_WIDTH-1:0] ch4_value;
  wire cap_ch3_overflow;
  wire cap_ch4_overflow;

  cpc_capture_chan #(
    .TB_WIDTH(TB_WIDTH)
  ) u_ch3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(cap_ch3_mode_reg),
    .cap_pin(cap_ch3_pin),
    .capture_timebase(capture_timebase),
    .rd_lo(ch3_rd_lo),
    .rd_hi(ch3_rd_hi),
    .value_reg(ch3_value),
    .overflow_reg(cap_ch3_overflow)
  );

  cpc_capture_chan #(
    .TB_WIDTH(TB_WIDTH)
  ) u_ch4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(cap_ch4_mode_reg),
    .cap_pin(cap_ch4_pin),
    .capture_timebase(capture_timebase),
    .rd_lo(ch4_rd_lo),
    .rd_hi(ch4_rd_hi),
    .value_reg(ch4_value),
    .overflow_reg(cap_ch4_overflow)
  );

  // ----------------------------------------------------------------
  // Read data multiplexer
  // ----------------------------------------------------------------
  // Bytes sit in the low eight bits; bit 7 of control reads zero
  always @* begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (rd_addr)
      `CPC_OFF_CTRL: begin
        rd_data[`CPC_BIT_PULSE3_EN] = pulse_out3_enable_reg;
        rd_data[`CPC_BIT_CH3_SEL_HI:`CPC_BIT_CH3_SEL_LO] = cap_ch3_mode_reg;
        rd_data[`CPC_BIT_CH4_SEL_HI:`CPC_BIT_CH4_SEL_LO] = cap_ch4_mode_reg;
        rd_data[`CPC_BIT_CH3_OVF] = cap_ch3_overflow;
        rd_data[`CPC_BIT_CH4_OVF] = cap_ch4_overflow;
      end
      `CPC_OFF_CH3_LO: rd_data[7:0] = ch3_value[7:0];
      `CPC_OFF_CH3_HI: rd_data[7:0] = ch3_value[TB_WIDTH-1:TB_WIDTH-8];
      `CPC_OFF_CH4_LO: rd_data[7:0] = ch4_value[7:0];
      `CPC_OFF_CH4_HI: rd_data[7:0] = ch4_value[TB_WIDTH-1:TB_WIDTH-8];
      default: rd_err = 1'b1;
    endcase
  end

  // Capture registers are read only, so writing them is an error
  always @* begin
    wr_err = (wr_addr != `CPC_OFF_CTRL);
  end

  // ----------------------------------------------------------------
  // Shared pin steering
  // ----------------------------------------------------------------
  // Registered so the pin never glitches while the enable changes
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out3_pin_out <= 1'b0;
      pulse_out3_pin_oe <= 1'b0;
    end else if (pulse_out3_enable_reg) begin
      pulse_out3_pin_out <= pulse_out3_wave;
      pulse_out3_pin_oe <= 1'b1;
    end else begin
      pulse_out3_pin_out <= port_data_out;
      pulse_out3_pin_oe <= ~port_dir_input;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cpc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.vh"
// ----------------------------
// Bus and pin checker
// ----------------------------
module cpc_top_sva #(
  parameter ADDR_WIDTH = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared pin
  input wire logic pulse_out3_wave,
  input wire logic port_dir_input,
  input wire logic pulse_out3_pin_out,
  input wire logic pulse_out3_pin_oe
);
  logic [ADDR_WIDTH-1:0] addr_reg;
  // Keep the read address so its answer can be judged
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      addr_reg <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answer pending");
  a_ctrl_top_zero: assert property (
    s_axi_rvalid && addr_reg == 5'h00 |-> s_axi_rdata[31:7] == 25'h0)
    else $error("control top bits not zero");
  a_unmapped_err: assert property (
    s_axi_rvalid && addr_reg > 5'h10
    |-> s_axi_rresp == `CPC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_oe_when_out: assert property (
    $past(aresetn) && !$past(port_dir_input) |-> pulse_out3_pin_oe)
    else $error("output direction not driven");
  a_wave_follow: assert property (
    $past(aresetn) && pulse_out3_pin_oe && $past(port_dir_input)
    |-> pulse_out3_pin_out == $past(pulse_out3_wave))
    else $error("pin does not follow wave");
endmodule
`default_nettype wire

// ===== tb/cpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Capture pins and wave source
// ----------------------------
module cpc_pin_model (
  // Clock
  input wire logic aclk,
  // Timebase and capture pins
  output logic [15:0] capture_timebase,
  output logic cap_ch3_pin,
  output logic cap_ch4_pin,
  // Wave into the output mux
  output logic pulse_out3_wave
);
  logic hold_reg = 1'b0;
  logic [15:0] hold_val = 16'h0;
  logic [1:0] pins_reg = 2'h0;
  logic [15:0] count_reg = 16'h0;
  logic wave_reg = 1'b0;
  assign cap_ch3_pin = pins_reg[0];
  assign cap_ch4_pin = pins_reg[1];
  assign capture_timebase = count_reg;
  assign pulse_out3_wave = wave_reg;
  // Count runs free between pulses, so a late sample is caught
  always @(posedge aclk) begin
    count_reg <= hold_reg ? hold_val : count_reg + 16'h1;
    wave_reg <= ~wave_reg;
  end
  // One pulse; the falling edge sees the inverted value
  task automatic pulse(input int ch, input logic [15:0] v);
    @(posedge aclk);
    hold_reg <= 1'b1;
    hold_val <= v;
    @(posedge aclk);
    pins_reg[ch] <= 1'b1;
    repeat (4) @(posedge aclk);
    hold_val <= ~v;
    @(posedge aclk);
    pins_reg[ch] <= 1'b0;
    repeat (4) @(posedge aclk);
    hold_reg <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/capture3_4_pwm3_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.vh"
// ----------------------------
// Self-checking bench
// ----------------------------
module capture3_4_pwm3_control_tb;
  logic aclk, aresetn, port_dir_input, port_data_out, e;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, pulse_out3_pin_out, pulse_out3_pin_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] capture_timebase;
  wire cap_ch3_pin, cap_ch4_pin, pulse_out3_wave;
  int n_mismatch = 0;
  int checked = 0;
  int n;
  logic [15:0] v;
  cpc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_timebase,
    .cap_ch3_pin, .cap_ch4_pin, .pulse_out3_wave, .port_dir_input,
    .port_data_out, .pulse_out3_pin_out, .pulse_out3_pin_oe);
  cpc_pin_model pins (.aclk, .capture_timebase, .cap_ch3_pin,
    .cap_ch4_pin, .pulse_out3_wave);
  task automatic chk_data(input logic [31:0] got, input logic [31:0] x);
    checked++;
    if (got !== x) begin
      n_mismatch++;
      $display("Error %0t: data %h, expected %h", $time, got, x);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] x);
    checked++;
    if (got !== x) begin
      n_mismatch++;
      $display("Error %0t: response %h, expected %h", $time, got, x);
    end
  endtask
  task automatic chk_pin(input logic got, input logic x);
    checked++;
    if (got !== x) begin
      n_mismatch++;
      $display("Error %0t: pin %b, expected %b", $time, got, x);
    end
  endtask
  // Read: hold the address until taken, rready until the answer
  task automatic rd(input logic [4:0] a, input logic [31:0] x,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk_data(s_axi_rdata, x);
    chk_resp(s_axi_rresp, r);
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    @(posedge aclk);
    while (!s_axi_bvalid) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    chk_resp(s_axi_bresp, r);
  endtask
  task automatic rd_pair(input int c, input logic [15:0] x);
    rd(c ? 5'h0c : 5'h04, {24'h0, x[7:0]}, `CPC_RESP_OKAY);
    rd(c ? 5'h10 : 5'h08, {24'h0, x[15:8]}, `CPC_RESP_OKAY);
  endtask
  // Control word for mode m on channel c (0 is channel 3), flag optional
  function automatic logic [31:0] exp_ctrl(input int c, input int m,
                                           input bit ovf);
    exp_ctrl = (32'(m) << (`CPC_BIT_CH3_SEL_LO + 2 * c))
             | (32'(ovf) << (`CPC_BIT_CH3_OVF + c));
  endfunction
  // Falling-edge mode sees the value the pin model shows after the fall
  function automatic logic [15:0] exp_cap(input int m,
                                          input logic [15:0] x);
    exp_cap = (m == 0) ? ~x : x;
  endfunction
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Whole run needs about a thousand cycles; this leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, port_data_out} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    s_axi_wstrb = 4'hf;
    port_dir_input = 1'b1;
    n = $urandom(32'h3de513bd);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, refusals and read-only status bits
    rd(5'h00, 32'h0, `CPC_RESP_OKAY);
    rd_pair(0, 16'h0);
    rd_pair(1, 16'h0);
    rd(5'h14, 32'h0, `CPC_RESP_SLVERR);
    wr(5'h04, 32'hff, `CPC_RESP_SLVERR);
    wr(5'h00, 32'hff, `CPC_RESP_OKAY);
    rd(5'h00, 32'h1f, `CPC_RESP_OKAY);
    $display("registers test done");
    // Each mode fires only on its own edge kind and count
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(5'h00, exp_ctrl(c, m, 1'b0), `CPC_RESP_OKAY);
        n = (m == 3) ? 16 : (m == 2) ? 4 : 1;
        repeat (n) begin
          v = 16'($urandom);
          pins.pulse(c, v);
        end
        rd_pair(c, exp_cap(m, v));
        rd(5'h00, exp_ctrl(c, m, 1'b0), `CPC_RESP_OKAY);
      end
    end
    $display("modes test done");
    // An overtaken capture freezes the pair until both bytes are read
    for (int c = 0; c < 2; c++) begin
      wr(5'h00, exp_ctrl(c, 1, 1'b0), `CPC_RESP_OKAY);
      v = 16'($urandom);
      pins.pulse(c, v);
      repeat (2) pins.pulse(c, 16'($urandom));
      rd(5'h00, exp_ctrl(c, 1, 1'b1), `CPC_RESP_OKAY);
      rd(c ? 5'h0c : 5'h04, {24'h0, v[7:0]}, `CPC_RESP_OKAY);
      pins.pulse(c, 16'($urandom));
      rd_pair(c, v);
      rd(5'h00, exp_ctrl(c, 1, 1'b0), `CPC_RESP_OKAY);
      v = 16'($urandom);
      pins.pulse(c, v);
      rd_pair(c, v);
    end
    $display("overflow test done");
    // Enable forces drive; otherwise the port direction decides
    repeat (16) begin
      e = 1'($urandom);
      wr(5'h00, {31'h0, e}, `CPC_RESP_OKAY);
      port_dir_input <= 1'($urandom);
      port_data_out <= 1'($urandom);
      repeat (2) @(posedge aclk);
      #1;
      chk_pin(pulse_out3_pin_oe, e | ~port_dir_input);
      // The pin took the wave level from before its last toggle
      if (e) begin
        chk_pin(pulse_out3_pin_out, ~pulse_out3_wave);
      end
      if (!e && !port_dir_input) begin
        chk_pin(pulse_out3_pin_out, port_data_out);
      end
    end
    $display("pin test done");
    close_out();
  end
endmodule
bind cpc_top cpc_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pulse_out3_wave, .port_dir_input,
  .pulse_out3_pin_out, .pulse_out3_pin_oe);
`default_nettype wire
